// [design/rvm_vector_map.sv]
// Purpose: reset entry and vector lookup of the interrupt controller
// Assumes: sources and cpu level come from logic on mclk; AXI4-Lite register bus
// Notes:   flags are cleared by software or by reset; reset never goes through the tables
`timescale 1ns/100ps
`include "rvm_consts.svh"
module rvm_vector_map
  import rvm_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // axi4-lite write channels
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // request sources
  input  wire logic [95:0]       src_req,
  input  wire logic [3:0]        trap_event,
  // cpu core
  input  wire logic [3:0]        cpu_level,
  output rvm_vec_type            vec_out,
  output logic [23:0]            entry_pc,
  output logic                   reset_fetch,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic [31:0]       rdata_ff;
  logic              aw_full_ff, w_full_ff;
  logic [5:0]        widx_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic [3:0]        trap_ff;
  logic              alt_ff;
  logic [1:0]        evt_stat_ff, evt_mask_ff;
  logic              irq_ff;
  logic              boot_done_ff, reset_fetch_ff;
  logic [23:0]       entry_pc_ff;
  rvm_vec_type       vec_ff;
  logic [2:0]        vec_pri_ff;
  rvm_vec_type       nxt_vec;
  logic [95:0]       flag_vec, en_vec, elig;
  logic [287:0]      pri_vec;
  wire  [383:0]      pri_flat;
  logic              win_found;
  logic [6:0]        win_num;
  logic [2:0]        win_pri;
  logic [6:0]        trap_num;

  // ----------------------------------------------------------------
  // output ports
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign vec_out       = vec_ff;
  assign entry_pc      = entry_pc_ff;
  assign reset_fetch   = reset_fetch_ff;
  assign irq           = irq_ff;

  // ----------------------------------------------------------------
  // bus write path
  // ----------------------------------------------------------------
  // address and data are held separately and joined once both are in
  wire aw_take     = s_axi_awvalid & awready_ff;
  wire w_take      = s_axi_wvalid & wready_ff;
  wire do_write    = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire nxt_aw_full = (aw_full_ff | aw_take) & ~do_write;
  wire nxt_w_full  = (w_full_ff | w_take) & ~do_write;

  // write decode on the held word index
  wire       wr_con1  = do_write & (widx_ff == `RVM_IDX_CON1);
  wire       wr_con2  = do_write & (widx_ff == `RVM_IDX_CON2);
  wire       wr_mask  = do_write & (widx_ff == `RVM_IDX_EVTMASK);
  wire       w_flag   = (widx_ff >= `RVM_IDX_FLAG) && (widx_ff < `RVM_IDX_FLAG + 6'd6);
  wire       w_en     = (widx_ff >= `RVM_IDX_EN) && (widx_ff < `RVM_IDX_EN + 6'd6);
  wire       w_pri    = (widx_ff >= `RVM_IDX_PRI) && (widx_ff < `RVM_IDX_PRI + 6'd24);
  wire       w_mapped = (widx_ff <= `RVM_IDX_EVTMASK) | w_flag | w_en | w_pri;

  // write handshake registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RVM_RESP_OKAY;
    end
    else
    begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff  <= nxt_w_full;
      awready_ff <= ~nxt_aw_full;
      wready_ff  <= ~nxt_w_full;
      bvalid_ff  <= do_write | (bvalid_ff & ~s_axi_bready);
      if (do_write)
        bresp_ff <= w_mapped ? `RVM_RESP_OKAY : `RVM_RESP_SLVERR;
    end
  end

  // write payload holding registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      widx_ff  <= 6'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (aw_take)
        widx_ff <= s_axi_awaddr[7:2];
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // ----------------------------------------------------------------
  // source slots and register packing
  // ----------------------------------------------------------------
  // flag, enable and priority positions follow from the vector number
  for (genvar i = 0; i < `RVM_NSRC; i++)
  begin : g_src
    localparam int W = i / 16;   // flag and enable word
    localparam int B = i % 16;   // bit within that word
    localparam int P = i / 4;    // priority word
    localparam int K = i % 4;    // field slot within it
    wire fl_hit = do_write & (widx_ff == 6'(`RVM_IDX_FLAG + W)) & wstrb_ff[B/8];
    wire en_hit = do_write & (widx_ff == 6'(`RVM_IDX_EN + W)) & wstrb_ff[B/8];
    wire pr_hit = do_write & (widx_ff == 6'(`RVM_IDX_PRI + P)) & wstrb_ff[K/2];
    rvm_src_slot #(
      .IMPL (1'(`RVM_IMPL_MASK >> i))
    ) u_slot (
      .mclk       (mclk),
      .reset      (reset),
      .src_req    (src_req[i]),
      .wr_flag    (fl_hit),
      .flag_wdata (wdata_ff[B]),
      .wr_en      (en_hit),
      .en_wdata   (wdata_ff[B]),
      .wr_pri     (pr_hit),
      .pri_wdata  (wdata_ff[4*K +: 3]),
      .flag_ff    (flag_vec[i]),
      .en_ff      (en_vec[i]),
      .pri_ff     (pri_vec[3*i +: 3])
    );
    assign pri_flat[16*P + 4*K +: 4] = {1'b0, pri_vec[3*i +: 3]};
    // pending, enabled and above the cpu level
    assign elig[i] = flag_vec[i] & en_vec[i] & ({1'b0, pri_vec[3*i +: 3]} > cpu_level);
  end

  // ----------------------------------------------------------------
  // trap flags and global control
  // ----------------------------------------------------------------
  // trap events set their status bits; a software write of zero clears them
  wire [3:0] nxt_trap = (wr_con1 & wstrb_ff[0] ? wdata_ff[`RVM_TRAP_LSB +: 4] : trap_ff) | trap_event;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      trap_ff     <= 4'h0;
      alt_ff      <= 1'b0;
      evt_mask_ff <= 2'h0;
    end
    else
    begin
      trap_ff <= nxt_trap;
      if (wr_con2 & wstrb_ff[1])
        alt_ff <= wdata_ff[`RVM_ALT_BIT];
      if (wr_mask & wstrb_ff[0])
        evt_mask_ff <= wdata_ff[1:0];
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // scan downward so that a tie hands the win to the lower vector number
  always_comb
  begin
    win_found = 1'b0;
    win_num   = 7'h00;
    win_pri   = 3'h0;
    for (int i = `RVM_NSRC - 1; i >= 0; i--)
    begin
      if (elig[i] && (!win_found || pri_vec[3*i +: 3] >= win_pri))
      begin
        win_found = 1'b1;
        win_num   = 7'(i);
        win_pri   = pri_vec[3*i +: 3];
      end
    end
  end

  // lowest pending trap number, traps 0, 5, 6 and 7 have no source
  assign trap_num = trap_ff[0] ? 7'h01 : trap_ff[1] ? 7'h02 :
                    trap_ff[2] ? 7'h03 : trap_ff[3] ? 7'h04 : 7'h00;

  // table address of the winner, traps ahead of user sources
  wire        trap_any  = |trap_ff;
  wire [6:0]  sel_num   = trap_any ? trap_num : win_num;
  wire [23:0] tbl_base  = trap_any ? `RVM_TRAP_BASE : `RVM_USER_BASE;
  wire [23:0] alt_add   = alt_ff ? `RVM_ALT_OFFSET : 24'h000000;
  assign nxt_vec.req  = boot_done_ff & (trap_any | win_found);
  assign nxt_vec.trap = trap_any;
  assign nxt_vec.num  = sel_num;
  assign nxt_vec.addr = tbl_base + alt_add + {16'h0000, sel_num, 1'b0};

  // ----------------------------------------------------------------
  // cpu side and reset entry
  // ----------------------------------------------------------------
  // reset entry: fetch restarts at the reset address, no table is read
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      boot_done_ff   <= 1'b0;
      reset_fetch_ff <= 1'b0;
      entry_pc_ff    <= `RVM_RESET_PC;
      vec_ff         <= '0;
      vec_pri_ff     <= 3'h0;
    end
    else
    begin
      boot_done_ff   <= 1'b1;
      reset_fetch_ff <= ~boot_done_ff;
      entry_pc_ff    <= `RVM_RESET_PC;
      vec_ff         <= nxt_vec;
      vec_pri_ff     <= win_pri;
    end
  end

  a_entry_zero: assert property (@(posedge mclk) disable iff (reset)
    reset_fetch_ff |-> entry_pc_ff == 24'h000000 && !vec_ff.req)
    else $error("reset entry not at address zero");
  a_boot_quiet: assert property (@(posedge mclk) disable iff (reset)
    !boot_done_ff |=> !vec_ff.req)
    else $error("vector requested during reset entry");
  a_trap_table: assert property (@(posedge mclk) disable iff (reset)
    vec_ff.req && vec_ff.trap |-> vec_ff.num >= 7'd1 && vec_ff.num <= 7'd4 &&
      vec_ff.addr == ($past(alt_ff) ? 24'h000104 : 24'h000004) + 24'({vec_ff.num, 1'b0}))
    else $error("trap vector address wrong");
  a_user_table: assert property (@(posedge mclk) disable iff (reset)
    vec_ff.req && !vec_ff.trap |->
      vec_ff.addr == ($past(alt_ff) ? 24'h000114 : 24'h000014) + 24'({vec_ff.num, 1'b0}))
    else $error("user vector address wrong");
  a_level_gate: assert property (@(posedge mclk) disable iff (reset)
    vec_ff.req && !vec_ff.trap |-> {1'b0, vec_pri_ff} > $past(cpu_level) &&
      $past(en_vec[win_num]) && $past(flag_vec[win_num]))
    else $error("request for an ineligible source");
  a_map_v19: assert property (@(posedge mclk) disable iff (reset)
    do_write && widx_ff == 6'h11 && wstrb_ff[0] |=>
      flag_vec[19] == ($past(wdata_ff[3]) | $past(src_req[19])))
    else $error("vector 19 flag not at bit 3 of word 1");
  a_map_v12: assert property (@(posedge mclk) disable iff (reset)
    do_write && widx_ff == 6'h23 && wstrb_ff[0] |=> pri_vec[36 +: 3] == $past(wdata_ff[2:0]))
    else $error("vector 12 priority not at bits 2:0 of word 3");
  a_map_v31: assert property (@(posedge mclk) disable iff (reset)
    do_write && widx_ff == 6'h27 && wstrb_ff[1] |=> pri_vec[93 +: 3] == $past(wdata_ff[14:12]))
    else $error("vector 31 priority not at bits 14:12 of word 7");
  a_map_v89: assert property (@(posedge mclk) disable iff (reset)
    do_write && widx_ff == 6'h36 && wstrb_ff[0] |=> pri_vec[267 +: 3] == $past(wdata_ff[6:4]))
    else $error("vector 89 priority not at bits 6:4 of word 22");

  // ----------------------------------------------------------------
  // bus read path and interrupt status
  // ----------------------------------------------------------------
  wire       ar_take = s_axi_arvalid & arready_ff;
  wire [5:0] ridx    = s_axi_araddr[7:2];
  wire       r_flag  = (ridx >= `RVM_IDX_FLAG) && (ridx < `RVM_IDX_FLAG + 6'd6);
  wire       r_en    = (ridx >= `RVM_IDX_EN) && (ridx < `RVM_IDX_EN + 6'd6);
  wire       r_pri   = (ridx >= `RVM_IDX_PRI) && (ridx < `RVM_IDX_PRI + 6'd24);
  wire [2:0] rf_i    = 3'(ridx - `RVM_IDX_FLAG);
  wire [2:0] re_i    = 3'(ridx - `RVM_IDX_EN);
  wire [4:0] rp_i    = 5'(ridx - `RVM_IDX_PRI);
  wire       r_map   = (ridx <= `RVM_IDX_EVTMASK) | r_flag | r_en | r_pri;

  // read selection, unimplemented positions come back as zero
  wire [15:0] rd_word =
    (ridx == `RVM_IDX_CON1)    ? {11'h000, trap_ff, 1'b0} :
    (ridx == `RVM_IDX_CON2)    ? {alt_ff, 15'h0000} :
    (ridx == `RVM_IDX_WIN)     ? {vec_ff.req, vec_ff.trap, 7'h00, vec_ff.num} :
    (ridx == `RVM_IDX_EVTSTAT) ? {14'h0000, evt_stat_ff} :
    (ridx == `RVM_IDX_EVTMASK) ? {14'h0000, evt_mask_ff} :
    r_flag                     ? flag_vec[16*rf_i +: 16] :
    r_en                       ? en_vec[16*re_i +: 16] :
    r_pri                      ? pri_flat[16*rp_i +: 16] : `RVM_REG_RESET;

  // events: bit 0 a new vector request, bit 1 a trap; reading the status clears it
  wire [1:0] evt_now  = {|trap_event, nxt_vec.req & ~vec_ff.req};
  wire       stat_clr = ar_take & (ridx == `RVM_IDX_EVTSTAT);
  wire [1:0] nxt_stat = (stat_clr ? 2'h0 : evt_stat_ff) | evt_now;

  // read handshake, data and interrupt output
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      arready_ff  <= 1'b0;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= 32'h0000_0000;
      rresp_ff    <= `RVM_RESP_OKAY;
      evt_stat_ff <= 2'h0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      arready_ff  <= ~(ar_take | (rvalid_ff & ~s_axi_rready));
      rvalid_ff   <= ar_take | (rvalid_ff & ~s_axi_rready);
      if (ar_take)
      begin
        rdata_ff <= {16'h0000, rd_word};
        rresp_ff <= r_map ? `RVM_RESP_OKAY : `RVM_RESP_SLVERR;
      end
      evt_stat_ff <= nxt_stat;
      irq_ff      <= |(nxt_stat & evt_mask_ff);
    end
  end

endmodule : rvm_vector_map

// [design/rvm_consts.svh]
// Purpose: constants for the reset entry and vector map block
// Assumes: 16-bit control words carried on a 32-bit register bus
// Notes:   register offsets are word indices; byte address is four times the index
`ifndef RVM_CONSTS_SVH
`define RVM_CONSTS_SVH

// ----------------------------------------------------------------
// map geometry
// ----------------------------------------------------------------
`define RVM_NSRC        96
`define RVM_NFLAGREG    6
`define RVM_NPRIREG     24
`define RVM_NTRAP       4
// one bit per vector number that has a real source behind it
`define RVM_IMPL_MASK   96'h3FBE_210E_4066_3FE3_FEDF_3FEF

// ----------------------------------------------------------------
// program addresses
// ----------------------------------------------------------------
`define RVM_RESET_PC    24'h000000
`define RVM_TRAP_BASE   24'h000004
`define RVM_USER_BASE   24'h000014
`define RVM_ALT_OFFSET  24'h000100

// ----------------------------------------------------------------
// register word indices
// ----------------------------------------------------------------
`define RVM_IDX_CON1    6'h00
`define RVM_IDX_CON2    6'h01
`define RVM_IDX_WIN     6'h02
`define RVM_IDX_EVTSTAT 6'h03
`define RVM_IDX_EVTMASK 6'h04
`define RVM_IDX_FLAG    6'h10
`define RVM_IDX_EN      6'h18
`define RVM_IDX_PRI     6'h20

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define RVM_TRAP_LSB    1
`define RVM_ALT_BIT     15
`define RVM_WIN_REQ_BIT 15
`define RVM_WIN_TRAP_BIT 14
`define RVM_REG_RESET   16'h0000
`define RVM_RESP_OKAY   2'h0
`define RVM_RESP_SLVERR 2'h2

`endif

// [design/rvm_pkg.sv]
// Purpose: shared types for the reset entry and vector map block
// Assumes: constants live in rvm_consts.svh
// Notes:   the vector bundle is what the cpu core samples
package rvm_pkg;

  // ----------------------------------------------------------------
  // request presented to the cpu core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        req;   // a vector is being requested
    logic        trap;  // winner is a trap vector
    logic [6:0]  num;   // vector number within its table
    logic [23:0] addr;  // table address to fetch
  } rvm_vec_type;

endpackage : rvm_pkg

// [design/rvm_src_slot.sv]
// Purpose: one interrupt source: sticky flag, enable bit, priority field
// Assumes: request and writes come from logic on mclk
// Notes:   an unimplemented slot holds zero forever
`timescale 1ns/100ps
module rvm_src_slot #(
  parameter bit IMPL = 1'b1
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // peripheral side
  input  wire logic       src_req,
  // register writes
  input  wire logic       wr_flag,
  input  wire logic       flag_wdata,
  input  wire logic       wr_en,
  input  wire logic       en_wdata,
  input  wire logic       wr_pri,
  input  wire logic [2:0] pri_wdata,
  // stored state
  output logic            flag_ff,
  output logic            en_ff,
  output logic [2:0]      pri_ff
);

  logic       nxt_flag;
  logic       nxt_en;
  logic [2:0] nxt_pri;

  // request sets, software write replaces, set wins over a clear
  assign nxt_flag = IMPL & ((wr_flag ? flag_wdata : flag_ff) | src_req);
  assign nxt_en   = IMPL & (wr_en ? en_wdata : en_ff);
  assign nxt_pri  = IMPL ? (wr_pri ? pri_wdata : pri_ff) : 3'h0;

  // state registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      flag_ff <= 1'b0;
      en_ff   <= 1'b0;
      pri_ff  <= 3'h0;
    end
    else
    begin
      flag_ff <= nxt_flag;
      en_ff   <= nxt_en;
      pri_ff  <= nxt_pri;
    end
  end

  a_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
    flag_ff && !wr_flag |=> flag_ff)
    else $error("request flag dropped without a software write");

  a_flag_set_wins: assert property (@(posedge mclk) disable iff (reset)
    IMPL && src_req |=> flag_ff)
    else $error("request did not set the flag");

  a_unimpl_quiet: assert property (@(posedge mclk) disable iff (reset)
    !IMPL |-> !flag_ff && !en_ff && pri_ff == 3'h0)
    else $error("unimplemented source holds state");

endmodule : rvm_src_slot

// [tb/rvm_src_model.sv]
// Purpose: peripheral request sources and cpu fetch stand-in
// Assumes: the bench asks for one-cycle requests on mclk
// Notes:   a released request line returns low
`timescale 1ns/100ps
module rvm_src_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // bench control
  input  wire logic        fire,
  input  wire logic [6:0]  num,
  // device side
  input  wire logic        reset_fetch,
  input  wire logic [23:0] entry_pc,
  output logic      [95:0] src_req,
  output logic      [3:0]  n_rst,
  output logic      [23:0] fetch_pc
);
  initial
  begin
    src_req  = '0;
    n_rst    = 4'h0;
    fetch_pc = 24'hFFFFFF;
  end

  // peripheral pulses its request line, then lets it fall
  always @(posedge mclk)
  begin
    src_req <= fire ? (96'h1 << num) : '0;
  end

  // cpu restarts at the entry address; reset never yields a table vector
  always @(posedge mclk)
  begin
    if (reset_fetch && !reset)
    begin
      n_rst    <= n_rst + 4'h1;
      fetch_pc <= entry_pc;
    end
  end
endmodule : rvm_src_model

// [tb/reset_entry_and_vector_map_tb.sv]
// Purpose: self-checking bench for the vector map
// Assumes: register access over axi4-lite, sources from rvm_src_model
// Notes:   expectations derive from base + 2n addressing
`timescale 1ns/100ps
`include "rvm_consts.svh"
module reset_entry_and_vector_map_tb
  import rvm_pkg::*;
;
  localparam logic [1:0] OK = `RVM_RESP_OKAY;
  logic        mclk = 1'b0, reset = 1'b1, fire = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, trap_event = 4'h0, cpu_level = 4'h0, n_rst;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_fetch, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  num = 7'h00;
  logic [95:0] src_req;
  logic [23:0] entry_pc, fetch_pc, ea;
  rvm_vec_type vec_out;
  int          n_errors = 0, n_tests = 0, c, n, t;
  int          cn[6] = '{19, 31, 89, 12, 0, 4};
  int          cp[6] = '{5, 7, 1, 3, 2, 7};
  int          cl[6] = '{0, 6, 0, 3, 0, 0};
  int          ca[6] = '{0, 0, 1, 0, 1, 0};
  int          ci[6] = '{1, 1, 1, 1, 1, 0};

  rvm_vector_map dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_req, .trap_event, .cpu_level,
    .vec_out, .entry_pc, .reset_fetch, .irq);
  rvm_src_model part (.mclk, .reset, .fire, .num, .reset_fetch, .entry_pc, .src_req, .n_rst, .fetch_pc);

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // ----------------------------------------------------------------
  // compare, bus and helper tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [32:0] exp, input logic [32:0] got);
  begin
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  end
  endtask : chk

  task close_out();
  begin
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask : close_out

  task bound(input int i);
  begin
    if (i == 40)
    begin
      n_errors++;
      close_out();
    end
  end
  endtask : bound

  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ka, kw, kb;
    logic [1:0] rs;
    int i;
  begin
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge mclk);
      ka = s_axi_awvalid & s_axi_awready;
      kw = s_axi_wvalid & s_axi_wready;
      kb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      if (kb)
      begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    bound(i);
    chk("bresp", {31'h0, er}, {31'h0, rs});
  end
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
    logic ka, kr;
    logic [31:0] dt;
    logic [1:0] rs;
    int i;
  begin
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge mclk);
      ka = s_axi_arvalid & s_axi_arready;
      kr = s_axi_rvalid;
      dt = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk);
      if (ka) s_axi_arvalid <= 1'b0;
      if (kr)
      begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    bound(i);
    chk("rdata", {17'h0, ed}, {1'b0, dt});
    chk("rresp", {31'h0, er}, {31'h0, rs});
  end
  endtask : rd

  task tick(input int k);
  begin
    repeat (k) @(posedge mclk);
  end
  endtask : tick

  task pulse(input int k);
  begin
    fire <= 1'b1;
    num  <= 7'(k);
    @(posedge mclk);
    fire <= 1'b0;
  end
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(10);
    reset <= 1'b0;
    tick(3);
    chk("rst_count", 33'(n_rst), 33'h1);
    chk("fetch_pc", 33'(fetch_pc), {9'h0, `RVM_RESET_PC});
    chk("idle_req", 33'(vec_out.req), 33'h0);
    for (c = 0; c < 6; c++)
    begin
      n  = cn[c];
      ea = `RVM_USER_BASE + 24'(2 * n) + (ca[c] != 0 ? `RVM_ALT_OFFSET : 24'h0);
      wr(8'h04, ca[c] != 0 ? 16'h8000 : 16'h0000, OK);
      wr(8'(8'h60 + 4 * (n / 16)), 16'(1 << (n % 16)), OK);
      wr(8'(8'h80 + 4 * (n / 4)), 16'(cp[c] << (4 * (n % 4))), OK);
      cpu_level <= 4'(cl[c]);
      pulse(n);
      tick(4);
      if (ci[c] != 0 && cp[c] > cl[c])
        chk("vector", {2'b10, 7'(n), ea}, vec_out);
      else
        chk("no_req", 33'h0, 33'(vec_out.req));
      rd(8'(8'h40 + 4 * (n / 16)), ci[c] != 0 ? 16'(1 << (n % 16)) : 16'h0, OK);
      rd(8'(8'h80 + 4 * (n / 4)), ci[c] != 0 ? 16'(cp[c] << (4 * (n % 4))) : 16'h0, OK);
      wr(8'(8'h40 + 4 * (n / 16)), 16'h0000, OK);
      tick(3);
      chk("cleared", 33'h0, 33'(vec_out.req));
    end
    // equal priority: lower vector number wins; one edge between the two pulses
    wr(8'h64, 16'h000C, OK);
    wr(8'h90, 16'h4400, OK);
    cpu_level <= 4'h0;
    pulse(19);
    tick(1);
    pulse(18);
    tick(4);
    chk("tie", {2'b10, 7'd18, `RVM_USER_BASE + 24'd36}, vec_out);
    wr(8'h44, 16'h0000, OK);
    // each trap source, alternating tables, above any cpu level
    for (t = 0; t < 4; t++)
    begin
      ea = `RVM_TRAP_BASE + 24'(2 * (t + 1)) + (t % 2 != 0 ? `RVM_ALT_OFFSET : 24'h0);
      wr(8'h04, t % 2 != 0 ? 16'h8000 : 16'h0000, OK);
      cpu_level  <= 4'hF;
      trap_event <= 4'(1 << t);
      @(posedge mclk);
      trap_event <= 4'h0;
      tick(4);
      chk("trap", {2'b11, 7'(t + 1), ea}, vec_out);
      rd(8'h08, 16'hC000 | 16'(t + 1), OK);
      rd(8'h00, 16'(2 << t), OK);
      wr(8'h00, 16'h0000, OK);
    end
    // interrupt: masked, raised, cleared by reading status
    chk("irq_masked", 33'h0, 33'(irq));
    wr(8'h10, 16'h0001, OK);
    tick(2);
    chk("irq_on", 33'h1, 33'(irq));
    rd(8'h0C, 16'h0003, OK);
    tick(2);
    chk("irq_off", 33'h0, 33'(irq));
    // unmapped place
    rd(8'hFC, 16'h0000, `RVM_RESP_SLVERR);
    wr(8'hFC, 16'h1234, `RVM_RESP_SLVERR);
    // reset in mid-run clears registers and restarts the fetch
    wr(8'h04, 16'h8000, OK);
    reset <= 1'b1;
    tick(3);
    reset <= 1'b0;
    tick(3);
    chk("rst_again", 33'(n_rst), 33'h2);
    rd(8'h04, 16'h0000, OK);
    close_out();
  end
endmodule : reset_entry_and_vector_map_tb
